// [common/ssla_pkg.sv]
package ssla_pkg;

  localparam int unsigned SSLA_ADDR_W = 3;
  localparam int unsigned SSLA_DATA_W = 8;

  // register offsets on the plain register port
  localparam logic [2:0] SSLA_OFS_DATA_LINE = 3'h0;
  localparam logic [2:0] SSLA_OFS_CLOCK_LINE = 3'h1;
  localparam logic [2:0] SSLA_OFS_CONTROL = 3'h2;
  localparam logic [2:0] SSLA_OFS_FALL_COND = 3'h3;
  localparam logic [2:0] SSLA_OFS_RISE_COND = 3'h4;
  localparam logic [2:0] SSLA_OFS_SAMPLED = 3'h5;
  localparam logic [2:0] SSLA_OFS_NEW_SAMPLE = 3'h6;

  // line_assist_control field positions
  localparam int unsigned SSLA_CTL_ENABLE = 0;
  localparam int unsigned SSLA_CTL_STRETCH_ALWAYS = 1;
  localparam int unsigned SSLA_CTL_STRETCH_COND = 2;
  localparam int unsigned SSLA_CTL_STRETCH_ACTIVE = 3;

  // values after reset
  localparam logic SSLA_RST_DATA_OUT = 1'b1;
  localparam logic SSLA_RST_CLOCK_OUT = 1'b1;
  localparam logic SSLA_RST_CTL_BIT = 1'b0;
  localparam logic SSLA_RST_FLAG = 1'b0;
  localparam logic SSLA_RST_SAMPLE = 1'b0;
  localparam logic [7:0] SSLA_RST_RDATA = 8'h00;

  // pad levels seen before the synchronisers fill (lines idle high)
  localparam logic SSLA_RST_PAD_LEVEL = 1'b1;

  // open-drain pads only ever pull low
  localparam logic SSLA_PAD_DRIVE_LEVEL = 1'b0;

endpackage

// [hw/ssla_sync.sv]
`timescale 1ns/1ps
module ssla_sync
  import ssla_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_reg;

  // meta_reg feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= SSLA_RST_PAD_LEVEL;
      sync_o <= SSLA_RST_PAD_LEVEL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule // ssla_sync

// [hw/ssla_sticky_flag.sv]
`timescale 1ns/1ps
module ssla_sticky_flag
  import ssla_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= SSLA_RST_FLAG;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // ssla_sticky_flag

// [hw/ssla_top.sv]
// Behaviour
// [R1] written data bit drives the data pad; resets to 1
// [R2] data register read returns the synchronised pad level; upper bits zero
// [R3] written clock bit drives the clock pad; resets to 1
// [R4] clock register read returns the synchronised pad level
// [R5] both pads are open drain; readback shows an outside pull low
// [R6] enable takes over both lines; while clear no condition flag sets
// [R7] data falling while clock high sets the falling-condition flag
// [R8] falling-condition flag resets to 0, cleared by any write to it
// [R9] each falling condition pulses its interrupt request
// [R10] data rising while clock high sets the rising-condition flag
// [R11] rising-condition flag resets to 0, cleared by any write to it
// [R12] each rising condition pulses its interrupt request
// [R13] always-stretch holds clock low after each falling edge, flags it
// [R14] conditional stretch holds clock low after fall if falling flag set
// [R15] any write to the sampled-data register ends stretching
// [R16] stretch flag read-only, resets 0; stretch enables reset to 0
// [R17] clock rising edge captures the data level into the sampled bit
// [R18] same edge sets new-sample flag; reading sampled data clears it
// [R19] when enabled the block owns the clock and data port lines
// [R20] both pad inputs are synchronised before edge detection
// [R21] clock pad pulled low when written bit is 0 or stretching
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module ssla_top
  import ssla_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [SSLA_ADDR_W-1:0] addr_i,
  input wire logic [SSLA_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SSLA_DATA_W-1:0] rdata_o,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  output logic port_lines_owned_o,
  output logic falling_cond_irq_o,
  output logic rising_cond_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad synchronisers and edge detection

  logic clk_s;
  logic dat_s;
  logic clk_d_reg;
  logic dat_d_reg;

  // [R20] pad input synchronisers
  ssla_sync u_sync_clock (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .async_i(serial_clock_line_i),
    .sync_o(clk_s)
  );

  ssla_sync u_sync_data (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .async_i(serial_data_line_i),
    .sync_o(dat_s)
  );

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_d_reg <= SSLA_RST_PAD_LEVEL;
      dat_d_reg <= SSLA_RST_PAD_LEVEL;
    end else begin
      clk_d_reg <= clk_s;
      dat_d_reg <= dat_s;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic clk_high;
  logic dat_rise;
  logic dat_fall;

  // [R20] one pulse per synchronised edge
  assign clk_rise = clk_s & ~clk_d_reg;
  assign clk_fall = ~clk_s & clk_d_reg;
  // clock must be high on both sides of the data edge
  assign clk_high = clk_s & clk_d_reg;
  assign dat_rise = dat_s & ~dat_d_reg;
  assign dat_fall = ~dat_s & dat_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_data_line;
  logic wr_clock_line;
  logic wr_control;
  logic wr_fall_cond;
  logic wr_rise_cond;
  logic wr_sampled;
  logic rd_sampled;

  assign wr_data_line = wr_i && (addr_i == SSLA_OFS_DATA_LINE);
  assign wr_clock_line = wr_i && (addr_i == SSLA_OFS_CLOCK_LINE);
  assign wr_control = wr_i && (addr_i == SSLA_OFS_CONTROL);
  assign wr_fall_cond = wr_i && (addr_i == SSLA_OFS_FALL_COND);
  assign wr_rise_cond = wr_i && (addr_i == SSLA_OFS_RISE_COND);
  assign wr_sampled = wr_i && (addr_i == SSLA_OFS_SAMPLED);
  assign rd_sampled = rd_i && (addr_i == SSLA_OFS_SAMPLED);

  ////////////////////////////////////////////////////////////////////////////
  // software-written bits

  logic data_line_out_bit_reg;
  logic clock_line_out_bit_reg;
  logic assist_enable_reg;
  logic stretch_always_en_reg;
  logic stretch_on_falling_cond_en_reg;

  // [R1] data output bit
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_line_out_bit_reg <= SSLA_RST_DATA_OUT;
    end else if (wr_data_line) begin
      data_line_out_bit_reg <= wdata_i[0];
    end
  end

  // [R3] clock output bit
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clock_line_out_bit_reg <= SSLA_RST_CLOCK_OUT;
    end else if (wr_clock_line) begin
      clock_line_out_bit_reg <= wdata_i[0];
    end
  end

  // [R16] control bits; stretch flag is not writable
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      assist_enable_reg <= SSLA_RST_CTL_BIT;
      stretch_always_en_reg <= SSLA_RST_CTL_BIT;
      stretch_on_falling_cond_en_reg <= SSLA_RST_CTL_BIT;
    end else if (wr_control) begin
      assist_enable_reg <= wdata_i[SSLA_CTL_ENABLE];
      stretch_always_en_reg <= wdata_i[SSLA_CTL_STRETCH_ALWAYS];
      stretch_on_falling_cond_en_reg <= wdata_i[SSLA_CTL_STRETCH_COND];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition detection and stretching

  logic falling_evt;
  logic rising_evt;
  logic falling_cond_seen;
  logic rising_cond_seen;
  logic stretch_set;
  logic stretch_active;

  // [R6] no condition while disabled
  // [R7] data falls under a high clock
  assign falling_evt = assist_enable_reg && clk_high && dat_fall;
  // [R10] data rises under a high clock
  assign rising_evt = assist_enable_reg && clk_high && dat_rise;

  // [R8] falling-condition flag, write clears
  ssla_sticky_flag u_fall_flag (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .set_i(falling_evt),
    .clr_i(wr_fall_cond),
    .flag_o(falling_cond_seen)
  );

  // [R11] rising-condition flag, write clears
  ssla_sticky_flag u_rise_flag (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .set_i(rising_evt),
    .clr_i(wr_rise_cond),
    .flag_o(rising_cond_seen)
  );

  // [R13] [R14] stretch after a clock fall, always or on a seen condition
  assign stretch_set = assist_enable_reg && clk_fall &&
    (stretch_always_en_reg || (stretch_on_falling_cond_en_reg && falling_cond_seen));

  // [R15] write to sampled data releases the clock
  ssla_sticky_flag u_stretch_flag (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .set_i(stretch_set),
    .clr_i(wr_sampled),
    .flag_o(stretch_active)
  );

  // [R9] [R12] one-cycle request per detection
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      falling_cond_irq_o <= 1'b0;
      rising_cond_irq_o <= 1'b0;
    end else begin
      falling_cond_irq_o <= falling_evt;
      rising_cond_irq_o <= rising_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling on clock rise

  logic sampled_data_bit_reg;
  logic new_sample_pending;

  // [R17] data level at the clock rise
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sampled_data_bit_reg <= SSLA_RST_SAMPLE;
    end else if (clk_rise) begin
      sampled_data_bit_reg <= dat_s;
    end
  end

  // [R18] unread sample flag; a new edge beats the clearing read
  ssla_sticky_flag u_new_sample (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .set_i(clk_rise),
    .clr_i(rd_sampled),
    .flag_o(new_sample_pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad drive

  // [R5] [R19] [R21] open drain: enable only pulls low, and only when owned
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock_line_o <= SSLA_PAD_DRIVE_LEVEL;
      serial_data_line_o <= SSLA_PAD_DRIVE_LEVEL;
      serial_clock_line_oe_o <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
      port_lines_owned_o <= 1'b0;
    end else begin
      serial_clock_line_o <= SSLA_PAD_DRIVE_LEVEL;
      serial_data_line_o <= SSLA_PAD_DRIVE_LEVEL;
      serial_clock_line_oe_o <= assist_enable_reg &&
        (!clock_line_out_bit_reg || stretch_active);
      serial_data_line_oe_o <= assist_enable_reg && !data_line_out_bit_reg;
      port_lines_owned_o <= assist_enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [SSLA_DATA_W-1:0] rdata_next;

  // [R2] [R4] line registers read the pad, not the written bit
  always_comb begin
    rdata_next = SSLA_RST_RDATA;
    case (addr_i)
      SSLA_OFS_DATA_LINE: rdata_next[0] = dat_s;
      SSLA_OFS_CLOCK_LINE: rdata_next[0] = clk_s;
      SSLA_OFS_CONTROL: begin
        rdata_next[SSLA_CTL_ENABLE] = assist_enable_reg;
        rdata_next[SSLA_CTL_STRETCH_ALWAYS] = stretch_always_en_reg;
        rdata_next[SSLA_CTL_STRETCH_COND] = stretch_on_falling_cond_en_reg;
        rdata_next[SSLA_CTL_STRETCH_ACTIVE] = stretch_active;
      end
      SSLA_OFS_FALL_COND: rdata_next[0] = falling_cond_seen;
      SSLA_OFS_RISE_COND: rdata_next[0] = rising_cond_seen;
      SSLA_OFS_SAMPLED: rdata_next[0] = sampled_data_bit_reg;
      SSLA_OFS_NEW_SAMPLE: rdata_next[0] = new_sample_pending;
      default: rdata_next = SSLA_RST_RDATA;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= SSLA_RST_RDATA;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= SSLA_RST_RDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_disabled_no_cond: assert property ( // [R6]
    !assist_enable_reg |=> !falling_cond_irq_o && !rising_cond_irq_o
  ) else $error("condition raised while disabled");

  a_fall_cond_set: assert property ( // [R7]
    assist_enable_reg && clk_s && clk_d_reg && dat_d_reg && !dat_s
      |=> falling_cond_seen && falling_cond_irq_o
  ) else $error("falling condition missed");

  a_fall_cond_clear: assert property ( // [R8]
    wr_fall_cond && !falling_evt |=> !falling_cond_seen
  ) else $error("falling flag not cleared by write");

  a_fall_irq_pulse: assert property ( // [R9]
    falling_cond_irq_o |-> $past(dat_d_reg) && !$past(dat_s) && $past(clk_s)
  ) else $error("falling request without cause");

  a_rise_cond_set: assert property ( // [R10]
    assist_enable_reg && clk_s && clk_d_reg && !dat_d_reg && dat_s
      |=> rising_cond_seen && rising_cond_irq_o
  ) else $error("rising condition missed");

  a_rise_cond_clear: assert property ( // [R11]
    wr_rise_cond && !rising_evt |=> !rising_cond_seen
  ) else $error("rising flag not cleared by write");

  a_rise_irq_pulse: assert property ( // [R12]
    rising_cond_irq_o |-> !$past(dat_d_reg) && $past(dat_s) && $past(clk_d_reg)
  ) else $error("rising request without cause");

  a_stretch_always: assert property ( // [R13]
    assist_enable_reg && stretch_always_en_reg && clk_d_reg && !clk_s
      |=> stretch_active ##1 serial_clock_line_oe_o
  ) else $error("clock not stretched after fall");

  a_stretch_cond: assert property ( // [R14]
    assist_enable_reg && stretch_on_falling_cond_en_reg && falling_cond_seen &&
      clk_fall |=> stretch_active
  ) else $error("conditional stretch missed");

  a_stretch_release: assert property ( // [R15]
    wr_sampled && !stretch_set |=> !stretch_active
  ) else $error("stretch not released by write");

  a_stretch_idle: assert property ( // [R16]
    !stretch_always_en_reg && !stretch_on_falling_cond_en_reg && !stretch_active
      |=> !stretch_active
  ) else $error("stretch set while disabled");

  a_sample_capture: assert property ( // [R17]
    clk_rise |=> sampled_data_bit_reg == $past(dat_s)
  ) else $error("sample not captured at clock rise");

  a_sample_pending: assert property ( // [R18]
    clk_rise |=> new_sample_pending
  ) else $error("new-sample flag not set");

  a_sample_read_clear: assert property ( // [R18]
    rd_sampled && !clk_rise |=> !new_sample_pending
  ) else $error("new-sample flag not cleared by read");

  a_data_readback: assert property ( // [R2]
    rd_i && addr_i == SSLA_OFS_DATA_LINE |=> rdata_o == {7'h00, $past(dat_s)}
  ) else $error("data line readback wrong");

  a_clock_readback: assert property ( // [R4]
    rd_i && addr_i == SSLA_OFS_CLOCK_LINE |=> rdata_o[0] == $past(clk_s)
  ) else $error("clock line readback wrong");

  a_clock_drive: assert property ( // [R21]
    assist_enable_reg && (stretch_active || !clock_line_out_bit_reg)
      |=> serial_clock_line_oe_o && !serial_clock_line_o
  ) else $error("clock pad not pulled low");

  a_data_drive: assert property ( // [R1]
    wr_data_line ##1 assist_enable_reg |=> serial_data_line_oe_o == !$past(wdata_i[0], 2)
  ) else $error("data pad drive wrong");

  a_lines_released: assert property ( // [R19]
    !assist_enable_reg |=> !serial_clock_line_oe_o && !serial_data_line_oe_o
  ) else $error("pads driven while not owned");

endmodule // ssla_top

// [test/ssla_peer.sv]
`timescale 1ns/1ps
module ssla_peer (
  input wire logic clk_pad_i,
  output logic clk_pull_o,
  output logic data_pull_o
);
  initial begin
    clk_pull_o = 1'b0;
    data_pull_o = 1'b0;
  end
  task automatic set_data(input logic b);
    data_pull_o = ~b;
  endtask
  // data falls while clock high
  task automatic start_frame();
    #137 data_pull_o = 1'b1;
    #400;
  endtask
  // low data bit, then data rises while clock high
  task automatic stop_frame();
    // offset keeps pad moves off the rising core clock edges
    #13 clk_pull_o = 1'b1;
    #200 data_pull_o = 1'b1;
    #200 clk_pull_o = 1'b0;
    #200 data_pull_o = 1'b0;
    #400;
  endtask
  // release clock, then wait out any stretch before the high phase
  task automatic send_bit(input logic b);
    int n;
    // stretch must grab the pad before the release below
    #37 clk_pull_o = 1'b1;
    #200 data_pull_o = ~b;
    #200 clk_pull_o = 1'b0;
    n = 0;
    while (clk_pad_i !== 1'b1 && n < 400) begin
      #50 n++;
    end
    #400;
  endtask
endmodule // ssla_peer

// [test/ssla_top_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module ssla_top_bench;
  import ssla_pkg::*;
  logic core_clk, rst_n, wr, rd, clk_oe, clk_o, data_oe, data_o, owned, fall_irq, rise_irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic pull_clk, pull_data, clk_pad, data_pad, oe_seen;
  int fail_count = 0;
  int num_checks = 0;
  int fall_n = 0;
  int rise_n = 0;
  // wired-and with pull-up
  assign clk_pad = ~(clk_oe & ~clk_o) & ~pull_clk;
  assign data_pad = ~(data_oe & ~data_o) & ~pull_data;
  ssla_top dut_u (.core_clk_i(core_clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .serial_clock_line_i(clk_pad),
    .serial_clock_line_o(clk_o), .serial_clock_line_oe_o(clk_oe),
    .serial_data_line_i(data_pad), .serial_data_line_o(data_o),
    .serial_data_line_oe_o(data_oe), .port_lines_owned_o(owned),
    .falling_cond_irq_o(fall_irq), .rising_cond_irq_o(rise_irq));
  ssla_peer peer_u (.clk_pad_i(clk_pad), .clk_pull_o(pull_clk), .data_pull_o(pull_data));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (fall_irq === 1'b1) fall_n++;
    if (rise_irq === 1'b1) rise_n++;
    if (clk_oe === 1'b1) oe_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  task automatic wait_oe();
    int n;
    n = 0;
    while (clk_oe !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    #1 `CHK("stretch start", 1'b1, clk_oe)
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(SSLA_OFS_DATA_LINE, 8'h01, "data line");
    rd_chk(SSLA_OFS_CLOCK_LINE, 8'h01, "clock line");
    rd_chk(SSLA_OFS_CONTROL, 8'h00, "control");
    rd_chk(SSLA_OFS_FALL_COND, 8'h00, "falling flag");
    rd_chk(SSLA_OFS_RISE_COND, 8'h00, "rising flag");
    rd_chk(SSLA_OFS_SAMPLED, 8'h00, "sampled");
    rd_chk(SSLA_OFS_NEW_SAMPLE, 8'h00, "new sample");
    rd_chk(3'h7, 8'h00, "unmapped");
    `CHK("clock oe", 1'b0, clk_oe)
    `CHK("owned", 1'b0, owned)
  endtask
  task automatic t_lines();
    wr_reg(SSLA_OFS_DATA_LINE, 8'h00);
    cyc(3);
    `CHK("data oe off", 1'b0, data_oe)
    wr_reg(SSLA_OFS_CONTROL, 8'h01);
    cyc(3);
    `CHK("owned", 1'b1, owned)
    `CHK("data drive", 1'b0, data_o)
    `CHK("clock drive", 1'b0, clk_o)
    `CHK("data oe", 1'b1, data_oe)
    rd_chk(SSLA_OFS_DATA_LINE, 8'h00, "data pad low");
    rd_chk(SSLA_OFS_FALL_COND, 8'h01, "falling flag");
    wr_reg(SSLA_OFS_DATA_LINE, 8'hff);
    cyc(3);
    `CHK("data oe", 1'b0, data_oe)
    rd_chk(SSLA_OFS_DATA_LINE, 8'h01, "data pad");
    peer_u.set_data(1'b0);
    cyc(4);
    rd_chk(SSLA_OFS_DATA_LINE, 8'h00, "data pulled");
    peer_u.set_data(1'b1);
    wr_reg(SSLA_OFS_CLOCK_LINE, 8'hfe);
    cyc(3);
    `CHK("clock oe", 1'b1, clk_oe)
    rd_chk(SSLA_OFS_CLOCK_LINE, 8'h00, "clock pad");
    wr_reg(SSLA_OFS_CLOCK_LINE, 8'h01);
    cyc(3);
    `CHK("clock oe", 1'b0, clk_oe)
    rd_chk(SSLA_OFS_CLOCK_LINE, 8'h01, "clock pad");
    rd_chk(SSLA_OFS_NEW_SAMPLE, 8'h01, "new sample");
    rd_chk(SSLA_OFS_SAMPLED, 8'h01, "sampled");
    rd_chk(SSLA_OFS_NEW_SAMPLE, 8'h00, "new sample read");
    wr_reg(SSLA_OFS_CONTROL, 8'h0f);
    rd_chk(SSLA_OFS_CONTROL, 8'h07, "control");
    wr_reg(SSLA_OFS_FALL_COND, 8'h00);
    wr_reg(SSLA_OFS_RISE_COND, 8'h00);
  endtask
  task automatic t_cond();
    wr_reg(SSLA_OFS_CONTROL, 8'h00);
    fall_n = 0;
    rise_n = 0;
    peer_u.start_frame();
    peer_u.stop_frame();
    cyc(4);
    rd_chk(SSLA_OFS_FALL_COND, 8'h00, "falling off");
    rd_chk(SSLA_OFS_RISE_COND, 8'h00, "rising off");
    wr_reg(SSLA_OFS_CONTROL, 8'h01);
    peer_u.start_frame();
    rd_chk(SSLA_OFS_FALL_COND, 8'h01, "falling flag");
    `CHK("falling irq", 1, fall_n)
    wr_reg(SSLA_OFS_FALL_COND, 8'h5a);
    rd_chk(SSLA_OFS_FALL_COND, 8'h00, "falling clear");
    peer_u.stop_frame();
    rd_chk(SSLA_OFS_RISE_COND, 8'h01, "rising flag");
    `CHK("rising irq", 1, rise_n)
    `CHK("falling irq", 1, fall_n)
    wr_reg(SSLA_OFS_RISE_COND, 8'hff);
    rd_chk(SSLA_OFS_RISE_COND, 8'h00, "rising clear");
  endtask
  task automatic t_stretch();
    wr_reg(SSLA_OFS_CONTROL, 8'h03);
    fork
      peer_u.send_bit(1'b1);
      begin
        wait_oe();
        cyc(8);
        rd_chk(SSLA_OFS_CONTROL, 8'h0b, "stretching");
        rd_chk(SSLA_OFS_CLOCK_LINE, 8'h00, "clock held");
        wr_reg(SSLA_OFS_SAMPLED, 8'h00);
        rd_chk(SSLA_OFS_CONTROL, 8'h03, "released");
        `CHK("clock oe", 1'b0, clk_oe)
      end
    join
    rd_chk(SSLA_OFS_SAMPLED, 8'h01, "sampled");
    wr_reg(SSLA_OFS_CONTROL, 8'h05);
    wr_reg(SSLA_OFS_FALL_COND, 8'h00);
    oe_seen = 1'b0;
    peer_u.send_bit(1'b0);
    `CHK("no stretch", 1'b0, oe_seen)
    rd_chk(SSLA_OFS_SAMPLED, 8'h00, "sampled");
    peer_u.set_data(1'b1);
    peer_u.start_frame();
    fork
      peer_u.send_bit(1'b1);
      begin
        wait_oe();
        rd_chk(SSLA_OFS_CONTROL, 8'h0d, "cond stretch");
        wr_reg(SSLA_OFS_SAMPLED, 8'h00);
        rd_chk(SSLA_OFS_CONTROL, 8'h05, "released");
        `CHK("clock oe", 1'b0, clk_oe)
      end
    join
    rd_chk(SSLA_OFS_RISE_COND, 8'h01, "rising seen");
    // clear so the closing frame is not stretched again
    wr_reg(SSLA_OFS_FALL_COND, 8'h00);
    peer_u.stop_frame();
    wr_reg(SSLA_OFS_CONTROL, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    oe_seen = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_lines();
    t_cond();
    t_stretch();
    close_out();
  end
  initial begin
    #3000000;
    fail_count++;
    close_out();
  end
endmodule // ssla_top_bench
